// *** rtl/rfm_monitor.sv ***
// Fault supervision and power-good logic for core and bridge regulators
`timescale 1ns/10ps
`include "rfm_defs.svh"
module rfm_monitor (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         por_active_i,
  input  wire logic         enable_i,
  input  wire logic         soft_start_done_i,
  input  wire logic         core_oc_cmp_i,
  input  wire logic         core_short_cmp_i,
  input  wire logic         bridge_oc_cmp_i,
  input  wire logic         core_ov_cmp_i,
  input  wire logic         bridge_ov_cmp_i,
  input  wire logic         core_ov_rel_cmp_i,
  input  wire logic         bridge_ov_rel_cmp_i,
  input  wire logic         core_uv_cmp_i,
  input  wire logic         bridge_uv_cmp_i,
  output logic              output_good_flag_o,
  output logic              output_good_flag_oe_o,
  output logic              soft_start_o,
  output rfm_pkg::rfm_drv_t core_drv_o,
  output rfm_pkg::rfm_drv_t bridge_drv_o,
  output logic              overcurrent_fault_o,
  output logic              overvoltage_fault_o,
  output logic              undervoltage_fault_o
);
  rfm_pkg::rfm_cmp_t  cmp_s;
  rfm_pkg::rfm_state_t state_r;
  rfm_pkg::rfm_state_t state_nxt;
  logic [1:0]         ctl_s;
  logic               por_s;
  logic               en_s;
  logic               en_d_r;
  logic               en_rise;
  logic               core_oc_hit;
  logic               uv_hit;
  logic               oc_event;
  logic               uv_event;
  logic               ov_event;
  logic               core_clamp_r;
  logic               bridge_clamp_r;

  // All comparator levels are asynchronous to clk_i
  rfm_sync #(.W(9)) u_sync_cmp (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({core_oc_cmp_i, core_short_cmp_i, bridge_oc_cmp_i,
                 core_ov_cmp_i, bridge_ov_cmp_i, core_ov_rel_cmp_i,
                 bridge_ov_rel_cmp_i, core_uv_cmp_i, bridge_uv_cmp_i}),
    .sync_o    (cmp_s)
  );

  rfm_sync #(.W(2)) u_sync_ctl (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({por_active_i, enable_i}),
    .sync_o    (ctl_s)
  );
  assign por_s = ctl_s[1];
  assign en_s  = ctl_s[0];

  // Analog compare (5*Vc > Vset/6) is done in the comparator; here only qualified
  rfm_sustain #(.LIMIT(`RFM_OC_CYCLES)) u_oc_sustain (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cond_i    (cmp_s.core_oc),
    .hit_o     (core_oc_hit)
  );

  rfm_sustain #(.LIMIT(`RFM_UV_CYCLES)) u_uv_sustain (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .cond_i    (cmp_s.core_uv | cmp_s.bridge_uv),
    .hit_o     (uv_hit)
  );

  // Short circuit and bridge drop bypass the sustain delay
  assign oc_event = core_oc_hit | cmp_s.core_short | cmp_s.bridge_oc;
  assign uv_event = uv_hit && state_r == rfm_pkg::RFM_RUN;
  assign ov_event = en_s && (cmp_s.core_ov | cmp_s.bridge_ov);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= en_s;
    end
  end
  assign en_rise = en_s & ~en_d_r;

  // Overcurrent latch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || por_s) begin
      overcurrent_fault_o <= 1'b0;
    end else if (oc_event && en_s) begin
      overcurrent_fault_o <= 1'b1;
    end else if (en_rise) begin
      overcurrent_fault_o <= 1'b0;
    end
  end

  // Undervoltage latch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || por_s) begin
      undervoltage_fault_o <= 1'b0;
    end else if (uv_event && en_s) begin
      undervoltage_fault_o <= 1'b1;
    end else if (en_rise) begin
      undervoltage_fault_o <= 1'b0;
    end
  end

  // Overvoltage latch survives enable toggles; only supply reset clears
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || por_s) begin
      overvoltage_fault_o <= 1'b0;
    end else if (ov_event) begin
      overvoltage_fault_o <= 1'b1;
    end
  end

  // Clamp per offending output, hysteresis between 1.8 V and 0.85 V
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || por_s || !en_s) begin
      core_clamp_r <= 1'b0;
    end else if (cmp_s.core_ov) begin
      core_clamp_r <= 1'b1;
    end else if (!cmp_s.core_ov_rel) begin
      core_clamp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || por_s || !en_s) begin
      bridge_clamp_r <= 1'b0;
    end else if (cmp_s.bridge_ov) begin
      bridge_clamp_r <= 1'b1;
    end else if (!cmp_s.bridge_ov_rel) begin
      bridge_clamp_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rfm_pkg::RFM_OFF: begin
        if (en_rise && !overvoltage_fault_o) begin
          state_nxt = rfm_pkg::RFM_START;
        end
      end
      rfm_pkg::RFM_START: begin
        if (soft_start_done_i) begin
          state_nxt = rfm_pkg::RFM_RUN;
        end
      end
      rfm_pkg::RFM_RUN: begin
        state_nxt = rfm_pkg::RFM_RUN;
      end
      rfm_pkg::RFM_LATCHED: begin
        if (en_rise && !overvoltage_fault_o) begin
          state_nxt = rfm_pkg::RFM_START;
        end
      end
    endcase
    if (state_r != rfm_pkg::RFM_OFF && state_r != rfm_pkg::RFM_LATCHED) begin
      // A fault latched on the edge of an enable rise must still stop the start
      if (oc_event || uv_event || ov_event || overcurrent_fault_o
          || undervoltage_fault_o || overvoltage_fault_o) begin
        state_nxt = rfm_pkg::RFM_LATCHED;
      end
    end
    if (!en_s) begin
      state_nxt = (state_r == rfm_pkg::RFM_LATCHED) ? rfm_pkg::RFM_LATCHED
                                                      : rfm_pkg::RFM_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || por_s) begin
      state_r <= rfm_pkg::RFM_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Drivers run only in start and run; latched off tri-states all but an engaged low-side clamp
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      core_drv_o   <= '0;
      bridge_drv_o <= '0;
      soft_start_o <= 1'b0;
    end else begin
      core_drv_o.enable   <= state_nxt == rfm_pkg::RFM_START
                             || state_nxt == rfm_pkg::RFM_RUN;
      bridge_drv_o.enable <= state_nxt == rfm_pkg::RFM_START
                             || state_nxt == rfm_pkg::RFM_RUN;
      core_drv_o.low_clamp   <= core_clamp_r;
      bridge_drv_o.low_clamp <= bridge_clamp_r;
      soft_start_o <= state_nxt == rfm_pkg::RFM_START;
    end
  end

  // Open drain: the pin value is always 0, only the enable moves
  assign output_good_flag_o = 1'b0;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      output_good_flag_oe_o <= 1'b1;
    end else begin
      output_good_flag_oe_o <= !(state_nxt == rfm_pkg::RFM_RUN && en_s && !por_s
                                 && !overvoltage_fault_o && !ov_event
                                 && !cmp_s.core_uv && !cmp_s.bridge_uv
                                 && !oc_event);
    end
  end

  chk_good_low_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (overcurrent_fault_o || overvoltage_fault_o || undervoltage_fault_o)
      |-> output_good_flag_oe_o)
    else $error("power-good released during a fault");

  chk_good_low_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    soft_start_o |-> output_good_flag_oe_o)
    else $error("power-good released during soft-start");

  chk_pin_never_high: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    output_good_flag_o == 1'b0)
    else $error("power-good driven high");

  chk_oc_drv_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(overcurrent_fault_o) |=> !core_drv_o.enable && !bridge_drv_o.enable)
    else $error("drivers still on after overcurrent");

  chk_ov_sticky_en: assert property (@(posedge clk_i) disable iff (!reset_n_i || por_s)
    overvoltage_fault_o |=> overvoltage_fault_o)
    else $error("overvoltage latch cleared without supply reset");

  chk_short_fast: assert property (@(posedge clk_i) disable iff (!reset_n_i || por_s)
    (cmp_s.core_short && en_s) |=> overcurrent_fault_o)
    else $error("short circuit not latched next cycle");

  chk_ov_clamp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmp_s.core_ov && en_s && !por_s) ##1 1'b1 |=> core_drv_o.low_clamp)
    else $error("low-side clamp not engaged");

  chk_oc_brief_ign: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!cmp_s.core_oc ##1 cmp_s.core_oc[*8]) |-> !core_oc_hit)
    else $error("core overcurrent acted on too early");

  chk_uv_drv_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(undervoltage_fault_o) |=> !core_drv_o.enable && !bridge_drv_o.enable)
    else $error("drivers still on after undervoltage");

  // Undervoltage only counts once the outputs are regulating
  sequence s_uv_qualified;
    uv_hit && state_r == rfm_pkg::RFM_RUN && en_s;
  endsequence

  chk_uv_latch_set: assert property (@(posedge clk_i) disable iff (!reset_n_i || por_s)
    s_uv_qualified |=> undervoltage_fault_o)
    else $error("undervoltage not latched after sustain");

  chk_ov_latch_set: assert property (@(posedge clk_i) disable iff (!reset_n_i || por_s)
    ((cmp_s.core_ov || cmp_s.bridge_ov) && en_s) |=> overvoltage_fault_o)
    else $error("overvoltage not latched at once");

  chk_ov_no_start: assert property (@(posedge clk_i) disable iff (!reset_n_i || por_s)
    overvoltage_fault_o |=> !soft_start_o)
    else $error("soft-start begun with overvoltage latched");

  chk_good_low_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (por_s || !en_s) |=> output_good_flag_oe_o)
    else $error("power-good released while disabled");

  chk_clamp_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!cmp_s.core_ov && !cmp_s.core_ov_rel) |=> !core_clamp_r)
    else $error("core clamp held below release level");

  chk_bridge_clamp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cmp_s.bridge_ov && en_s && !por_s) ##1 1'b1 |=> bridge_drv_o.low_clamp)
    else $error("bridge low-side clamp not engaged");

  chk_oc_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !cmp_s.core_oc |=> !core_oc_hit)
    else $error("overcurrent sustain not restarted");

  chk_latched_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_r == rfm_pkg::RFM_LATCHED |-> !core_drv_o.enable && !bridge_drv_o.enable)
    else $error("drivers on while latched off");
endmodule : rfm_monitor

// *** rtl/rfm_defs.svh ***
// Constants for the regulator fault monitor
`ifndef RFM_DEFS_SVH
`define RFM_DEFS_SVH

`define RFM_CLK_MHZ        125
`define RFM_OC_SUSTAIN_US  100
`define RFM_UV_SUSTAIN_US  205
`define RFM_OC_CYCLES      (`RFM_OC_SUSTAIN_US * `RFM_CLK_MHZ)
`define RFM_UV_CYCLES      (`RFM_UV_SUSTAIN_US * `RFM_CLK_MHZ)
`define RFM_CNT_W          15

`endif

// *** rtl/rfm_pkg.sv ***
// Types for the regulator fault monitor
package rfm_pkg;

  // Synchronised comparator outputs
  typedef struct packed {
    logic core_oc;
    logic core_short;
    logic bridge_oc;
    logic core_ov;
    logic bridge_ov;
    logic core_ov_rel;
    logic bridge_ov_rel;
    logic core_uv;
    logic bridge_uv;
  } rfm_cmp_t;

  // Per-output driver command
  typedef struct packed {
    logic enable;
    logic low_clamp;
  } rfm_drv_t;

  typedef enum logic [1:0] {
    RFM_OFF     = 2'b00,
    RFM_START   = 2'b01,
    RFM_RUN     = 2'b10,
    RFM_LATCHED = 2'b11
  } rfm_state_t;

endpackage : rfm_pkg

// *** rtl/rfm_sync.sv ***
// Two-stage synchroniser for comparator and pin inputs
`timescale 1ns/10ps
module rfm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : rfm_sync

// *** rtl/rfm_sustain.sv ***
// Sustain counter: flags after a condition holds for LIMIT cycles
`timescale 1ns/10ps
`include "rfm_defs.svh"
module rfm_sustain #(
  parameter int LIMIT = 1
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic cond_i,
  output logic      hit_o
);
  localparam logic [`RFM_CNT_W-1:0] LAST = (`RFM_CNT_W)'(LIMIT - 1);
  logic [`RFM_CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !cond_i) begin
      cnt_r <= '0;
      hit_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      hit_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : rfm_sustain

// *** test/rfm_power_stage.sv ***
// Behavioural power stage, output sense and power-good pull-up
`timescale 1ns/10ps
module rfm_power_stage #(
  parameter int DIS = 6
) (
  input  wire logic              clk_i,
  input  wire logic [1:0]        ov_req_i,
  input  wire rfm_pkg::rfm_drv_t core_drv_i,
  input  wire rfm_pkg::rfm_drv_t bridge_drv_i,
  input  wire logic              good_data_i,
  input  wire logic              good_oe_i,
  output logic [1:0]             ov_cmp_o,
  output logic [1:0]             rel_cmp_o,
  output logic                   good_line_o
);
  logic [1:0] clamp;
  logic [1:0] over_r = 2'h0;
  logic [1:0] rel_r  = 2'h0;
  int         dis_cnt_r [2] = '{0, 0};

  assign clamp       = {bridge_drv_i.low_clamp, core_drv_i.low_clamp};
  assign ov_cmp_o    = over_r;
  assign rel_cmp_o   = rel_r;
  // Released line floats to the pull-up level
  assign good_line_o = good_oe_i ? good_data_i : 1'b1;

  // Clamp drags the output under 1.8 V at once, under 0.85 V after DIS+1 cycles
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (ov_req_i[k]) begin
        over_r[k]    <= 1'b1;
        rel_r[k]     <= 1'b1;
        dis_cnt_r[k] <= 0;
      end else if (clamp[k]) begin
        over_r[k] <= 1'b0;
        if (dis_cnt_r[k] == DIS) rel_r[k] <= 1'b0;
        else dis_cnt_r[k] <= dis_cnt_r[k] + 1;
      end
    end
  end
endmodule : rfm_power_stage

// *** test/rfm_monitor_tb.sv ***
// Self-checking bench for the regulator fault monitor
`timescale 1ns/10ps
module rfm_monitor_tb;
  logic clk_i = 1'b0, reset_n_i = 1'b0, por_active_i = 1'b0, enable_i = 1'b0;
  logic soft_start_done_i = 1'b0, core_oc_cmp_i = 1'b0, core_short_cmp_i = 1'b0;
  logic bridge_oc_cmp_i = 1'b0, core_uv_cmp_i = 1'b0, bridge_uv_cmp_i = 1'b0;
  logic [1:0] ov_req = 2'h0, ov_cmp, rel_cmp;
  logic good_data, good_oe, soft_start_o, good_line;
  logic ocf, ovf, uvf;
  rfm_pkg::rfm_drv_t core_drv, bridge_drv;
  int mismatches = 0, n_checks = 0, cycles = 0;

  always #4 clk_i = ~clk_i;

  rfm_monitor i_rfm_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .por_active_i(por_active_i), .enable_i(enable_i),
    .soft_start_done_i(soft_start_done_i), .core_oc_cmp_i(core_oc_cmp_i),
    .core_short_cmp_i(core_short_cmp_i), .bridge_oc_cmp_i(bridge_oc_cmp_i),
    .core_ov_cmp_i(ov_cmp[0]), .bridge_ov_cmp_i(ov_cmp[1]),
    .core_ov_rel_cmp_i(rel_cmp[0]), .bridge_ov_rel_cmp_i(rel_cmp[1]),
    .core_uv_cmp_i(core_uv_cmp_i), .bridge_uv_cmp_i(bridge_uv_cmp_i),
    .output_good_flag_o(good_data), .output_good_flag_oe_o(good_oe),
    .soft_start_o(soft_start_o), .core_drv_o(core_drv), .bridge_drv_o(bridge_drv),
    .overcurrent_fault_o(ocf), .overvoltage_fault_o(ovf), .undervoltage_fault_o(uvf));

  rfm_power_stage i_rfm_power_stage (.clk_i(clk_i), .ov_req_i(ov_req),
    .core_drv_i(core_drv), .bridge_drv_i(bridge_drv), .good_data_i(good_data),
    .good_oe_i(good_oe), .ov_cmp_o(ov_cmp), .rel_cmp_o(rel_cmp), .good_line_o(good_line));

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Enable toggle, soft-start, then run with both outputs good
  task automatic bring_up();
    enable_i = 1'b0;
    soft_start_done_i = 1'b0;
    step(5);
    enable_i = 1'b1;
    for (int i = 0; i < 20 && soft_start_o !== 1'b1; i++) step(1);
    chk(soft_start_o, 1);
    chk(good_line, 0);
    chk(core_drv.enable & bridge_drv.enable, 1);
    soft_start_done_i = 1'b1;
    step(3);
    chk(good_line, 1);
    chk({ocf, ovf, uvf}, 0);
  endtask : bring_up

  // Both regulators off, drivers tri-stated, power-good low
  task automatic shut_chk();
    chk({core_drv, bridge_drv}, 0);
    chk(good_line, 0);
  endtask : shut_chk

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    step(12);
    reset_n_i = 1'b1;
    step(3);
    chk(good_line, 0);
    bring_up();
    // Short circuit trips at once and stays off
    core_short_cmp_i = 1'b1;
    step(6);
    chk(ocf, 1);
    shut_chk();
    core_short_cmp_i = 1'b0;
    step(10);
    chk({ocf, soft_start_o}, 2'h2);
    bring_up();
    bridge_oc_cmp_i = 1'b1;
    step(6);
    chk(ocf, 1);
    shut_chk();
    bridge_oc_cmp_i = 1'b0;
    bring_up();
    // Excursion shorter than the sustain window is ignored
    core_oc_cmp_i = 1'b1;
    step(12000);
    core_oc_cmp_i = 1'b0;
    step(3);
    core_oc_cmp_i = 1'b1;
    step(12400);
    chk(ocf, 0);
    step(200);
    chk(ocf, 1);
    shut_chk();
    core_oc_cmp_i = 1'b0;
    bring_up();
    bridge_uv_cmp_i = 1'b1;
    step(25500);
    chk(uvf, 0);
    step(300);
    chk(uvf, 1);
    shut_chk();
    bridge_uv_cmp_i = 1'b0;
    bring_up();
    // Overvoltage clamps only the offending output
    ov_req = 2'h1;
    step(1);
    ov_req = 2'h0;
    step(6);
    chk(ovf, 1);
    chk({core_drv, bridge_drv}, 4'h4);
    chk(good_line, 0);
    step(20);
    chk({core_drv, bridge_drv}, 0);
    enable_i = 1'b0;
    step(5);
    enable_i = 1'b1;
    step(10);
    chk({ovf, soft_start_o}, 2'h2);
    ov_req = 2'h2;
    step(1);
    ov_req = 2'h0;
    step(6);
    chk(bridge_drv, 2'h1);
    step(20);
    chk(bridge_drv, 2'h0);
    por_active_i = 1'b1;
    step(5);
    chk(ovf, 0);
    chk(good_line, 0);
    por_active_i = 1'b0;
    bring_up();
    enable_i = 1'b0;
    step(5);
    chk(good_line, 0);
    close_out();
  end
endmodule : rfm_monitor_tb
